// >>> src/cpu_exec_pkg.sv
// Constants, types and decode helpers for the accumulator core
package cpu_exec_pkg;

   // ----------------------------------------------------------------
   // Widths and mapped register addresses
   // ----------------------------------------------------------------
   localparam int         PC_HIGH_WIDTH = 7;
   localparam int         PC_LOW_WIDTH  = 8;
   localparam logic [7:0] ADDR_PSW      = 8'hEF;
   localparam logic [7:0] ADDR_X        = 8'hFC;
   localparam logic [7:0] ADDR_SP       = 8'hFD;
   localparam logic [7:0] ADDR_B        = 8'hFE;
   localparam int         PSW_CARRY_BIT = 7;
   localparam int         PSW_HALF_BIT  = 6;
   localparam int         PSW_GIE_BIT   = 0;

   // ----------------------------------------------------------------
   // Reset values and arithmetic constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  RESET_BYTE    = 8'h00;
   localparam logic [7:0]  RESET_SP      = 8'h2F;
   localparam logic [14:0] RESET_PC      = 15'h0000;
   localparam logic [7:0]  DEC_LOW_FIX   = 8'h06;
   localparam logic [7:0]  DEC_HIGH_FIX  = 8'h60;
   localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0]  BCD_BYTE_MAX  = 8'h99;

   // ----------------------------------------------------------------
   // Opcodes and opcode groups
   // ----------------------------------------------------------------
   localparam logic [3:0] GRP_PTR_NIBBLE = 4'h4;
   localparam logic [3:0] GRP_ALU_PTR    = 4'h8;
   localparam logic [3:0] GRP_ALU_IMM    = 4'h9;
   localparam logic [3:0] GRP_ALU_DIR    = 4'hA;
   localparam logic [3:0] GRP_MOVE       = 4'hB;
   localparam logic [3:0] GRP_MISC       = 4'hC;
   localparam logic [4:0] GRP_BITCLR_PTR = 5'h0D;
   localparam logic [4:0] GRP_BITTST_PTR = 5'h0E;
   localparam logic [4:0] GRP_BITSET_PTR = 5'h0F;
   localparam logic [4:0] GRP_BITSET_DIR = 5'h1A;
   localparam logic [4:0] GRP_BITCLR_DIR = 5'h1B;
   localparam logic [4:0] GRP_BITTST_DIR = 5'h1C;
   localparam logic [4:0] GRP_BITTST_ACC = 5'h1D;
   localparam logic [7:0] OP_AND_SKIP    = 8'h60;
   localparam logic [7:0] OP_DEC_ADJUST  = 8'h66;
   localparam logic [7:0] OP_PUSH        = 8'h67;
   localparam logic [7:0] OP_DEC_SKIP    = 8'hF0;
   localparam logic [7:0] OP_TABLE       = 8'hC3;
   localparam logic [7:0] OP_POP         = 8'hCB;
   localparam logic [7:0] OP_VECTOR      = 8'hCC;
   // ALU function codes (low nibble of the ALU groups)
   localparam logic [3:0] FN_ADD = 4'h0, FN_ADC = 4'h1, FN_SUBTRACT_BORROW_OP = 4'h2, FN_AND = 4'h3;
   localparam logic [3:0] FN_OR = 4'h4, FN_XOR = 4'h5, FN_EQ = 4'h6, FN_NE = 4'h7;
   localparam logic [3:0] FN_GT = 4'h8, FN_LOAD = 4'h9, FN_XCH = 4'hA;

   typedef enum {ST_OPCODE, ST_OPERAND, ST_EXECUTE, ST_VECTOR_LOW} core_state_type;

   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic global_irq_enable;
   } psw_type;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic [7:0] wdata;
   } data_req_type;

   // Number of bytes of an instruction, opcode included
   function automatic logic [1:0] instr_length(input logic [7:0] opc);
      logic [1:0] n;
      n = 2'h1;
      if (opc == OP_AND_SKIP || opc == OP_DEC_SKIP || opc[7:4] == GRP_ALU_IMM || opc[7:4] == GRP_ALU_DIR ||
          opc[7:3] == GRP_BITSET_DIR || opc[7:3] == GRP_BITCLR_DIR || opc[7:3] == GRP_BITTST_DIR)
         n = 2'h2;
      if (opc[7:4] == GRP_MOVE && opc[3:0] >= 4'hA)
         n = (opc[3:0] >= 4'hD) ? 2'h3 : 2'h2;
      return n;
   endfunction

endpackage

// >>> src/cpu_instruction_execute.sv
// Instruction decode and execute for the 8-bit accumulator core
// Operation
// - Accumulator, two pointers, stack pointer; 15-bit counter split 7 upper, 8 lower.
// - Status word holds carry, half carry and global interrupt enable.
// - Add with carry sums operand and carry, sets carry and half carry.
// - Subtract with carry uses carry as inverted borrow, sets both flags.
// - AND immediate skip: skip next when result zero, accumulator unchanged.
// - Memory-equal-immediate runs next only when equal.
// - Accumulator compares run next only if equal, unequal or greater holds.
// - Pointer nibble test runs next only when low nibble differs.
// - Decrement register, skip next when result is zero.
// - Bit set and clear write one bit, number 0 to 7 from opcode.
// - Clear-pending clears software pending flag only.
// - Exchange swaps accumulator with direct or pointer memory.
// - Pointer moves B2 to BB access first, then step the pointer by one.
// - Register load immediate writes mapped registers, pointers included.
// - Table lookup reads program byte at upper counter and accumulator.
// - Decimal adjust corrects accumulator after add or subtract with carry.
// - Rotates go through carry; shifted out bit becomes carry.
// - Carry tests run next only when carry matches the form.
// - Pop increments stack pointer, then loads accumulator.
// - Push stores accumulator, then decrements stack pointer.
// - Vector dispatch loads counter parts from vector entry bytes.
// - A skipped instruction costs one cycle per byte.
`timescale 1ns/1ns
module cpu_instruction_execute
   import cpu_exec_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   output logic [14:0]       prog_addr,
   input  wire logic [7:0]   prog_data,
   output data_req_type      data_req,
   input  wire logic [7:0]   data_rdata,
   input  wire logic [14:0]  vector_addr,
   output logic              clear_soft_pending,
   output psw_type           psw_flags,
   output logic              skip_active
);

   // ----------------------------------------------------------------
   // Architectural state
   // ----------------------------------------------------------------
   core_state_type   state;
   logic [7:0]       acc;
   logic [7:0]       ptr_b;
   logic [7:0]       ptr_x;
   logic [7:0]       sp;
   logic [6:0]       pc_high_part;
   logic [7:0]       pc_low_part;
   psw_type          psw;
   logic [7:0]       op;
   logic [7:0]       byte1;
   logic [7:0]       byte2;
   logic             operand_index;
   logic             skip;
   logic             last_sub;

   logic [7:0]       next_acc, next_b, next_x, next_sp;
   psw_type          next_psw;
   logic             next_last_sub;
   logic             test_skip;
   logic [7:0]       eff_addr;
   logic [7:0]       mem_val;
   logic [7:0]       alu_opnd, alu_m, dec_val;
   logic [8:0]       sum9;
   logic [4:0]       half5;
   logic [14:0]      pc_next;
   logic             mapped_write;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] a);
      return a == ADDR_B || a == ADDR_X || a == ADDR_SP || a == ADDR_PSW;
   endfunction

   function automatic logic [7:0] read_space(input logic [7:0] a);
      logic [7:0] v;
      v = data_rdata;
      if (a == ADDR_B) v = ptr_b;
      if (a == ADDR_X) v = ptr_x;
      if (a == ADDR_SP) v = sp;
      if (a == ADDR_PSW) begin
         v = 8'h00;
         v[PSW_CARRY_BIT] = psw.carry;
         v[PSW_HALF_BIT]  = psw.half_carry_flag;
         v[PSW_GIE_BIT]   = psw.global_irq_enable;
      end
      return v;
   endfunction

   assign pc_next     = {pc_high_part, pc_low_part} + 15'h0001;
   assign psw_flags   = psw;
   assign skip_active = skip;

   // ----------------------------------------------------------------
   // Operand address and program address
   // ----------------------------------------------------------------
   always_comb begin
      eff_addr = byte1;
      if (op[7:4] == GRP_ALU_PTR || op[7:3] == GRP_BITCLR_PTR || op[7:3] == GRP_BITTST_PTR ||
          op[7:3] == GRP_BITSET_PTR)
         eff_addr = ptr_b;
      if (op[7:4] == GRP_MOVE && op[3:0] <= 4'hC) begin
         unique case (op[3:0])
            4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9: eff_addr = ptr_x;
            default:                            eff_addr = ptr_b;
         endcase
      end
      if (op == OP_PUSH) eff_addr = sp;
      if (op == OP_POP) eff_addr = sp + 8'h01;
   end

   always_comb mem_val = read_space(eff_addr);
   assign alu_opnd = (op[7:4] == GRP_ALU_IMM) ? byte1 : mem_val;
   assign alu_m    = (op[3:0] == FN_SUBTRACT_BORROW_OP) ? ~alu_opnd : alu_opnd;
   assign sum9     = {1'b0, acc} + {1'b0, alu_m} + {8'h00, psw.carry};
   assign half5    = {1'b0, acc[3:0]} + {1'b0, alu_m[3:0]} + {4'h0, psw.carry};

   always_comb begin
      prog_addr = {pc_high_part, pc_low_part};
      if (state == ST_EXECUTE && op == OP_TABLE)
         prog_addr = {pc_high_part, acc};
      if (state == ST_EXECUTE && op == OP_VECTOR)
         prog_addr = vector_addr;
      if (state == ST_VECTOR_LOW)
         prog_addr = vector_addr + 15'h0001;
   end

   // Decimal correction, direction from the last add or subtract with carry
   always_comb begin
      dec_val = acc;
      if (!last_sub) begin
         if (psw.half_carry_flag || acc[3:0] > BCD_DIGIT_MAX) dec_val = dec_val + DEC_LOW_FIX;
         if (psw.carry || acc > BCD_BYTE_MAX) dec_val = dec_val + DEC_HIGH_FIX;
      end else begin
         if (!psw.half_carry_flag) dec_val = dec_val - DEC_LOW_FIX;
         if (!psw.carry) dec_val = dec_val - DEC_HIGH_FIX;
      end
   end

   // ----------------------------------------------------------------
   // Execute
   // ----------------------------------------------------------------
   always_comb begin
      next_acc = acc;
      next_b = ptr_b;
      next_x = ptr_x;
      next_sp = sp;
      next_psw = psw;
      next_last_sub = last_sub;
      test_skip = 1'b0;
      clear_soft_pending = 1'b0;
      data_req = '{addr: eff_addr, write: 1'b0, wdata: acc};
      if (state == ST_EXECUTE) begin
         unique casez (op)
            8'b0100_????: test_skip = (ptr_b[3:0] == op[3:0]);
            OP_AND_SKIP:  test_skip = ((acc & byte1) == 8'h00);
            OP_DEC_ADJUST: begin
               next_acc = dec_val;
               if (!last_sub && (psw.carry || acc > BCD_BYTE_MAX)) next_psw.carry = 1'b1;
            end
            OP_PUSH: begin
               data_req.write = 1'b1;
               next_sp = sp - 8'h01;
            end
            8'b0110_1???, 8'b0111_1???, 8'b1101_????: begin
               data_req.write = 1'b1;
               data_req.wdata = mem_val;
               data_req.wdata[op[2:0]] = (op[7:3] == GRP_BITSET_PTR || op[7:3] == GRP_BITSET_DIR);
            end
            8'b0111_0???, 8'b1110_0???: test_skip = !mem_val[op[2:0]];
            8'b1110_1???: test_skip = !acc[op[2:0]];
            OP_DEC_SKIP: begin
               data_req.write = 1'b1;
               data_req.wdata = mem_val - 8'h01;
               test_skip = (mem_val == 8'h01);
            end
            8'b1000_????, 8'b1001_????, 8'b1010_????: begin
               unique case (op[3:0])
                  FN_ADD:  next_acc = acc + alu_opnd;
                  FN_ADC, FN_SUBTRACT_BORROW_OP: begin
                     next_acc = sum9[7:0];
                     next_psw.carry = sum9[8];
                     next_psw.half_carry_flag = half5[4];
                     next_last_sub = (op[3:0] == FN_SUBTRACT_BORROW_OP);
                  end
                  FN_AND:  next_acc = acc & alu_opnd;
                  FN_OR:   next_acc = acc | alu_opnd;
                  FN_XOR:  next_acc = acc ^ alu_opnd;
                  FN_EQ:   test_skip = (acc != alu_opnd);
                  FN_NE:   test_skip = (acc == alu_opnd);
                  FN_GT:   test_skip = !(acc > alu_opnd);
                  FN_LOAD: next_acc = alu_opnd;
                  FN_XCH: begin
                     if (op[7:4] != GRP_ALU_IMM) begin
                        next_acc = mem_val;
                        data_req.write = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
            8'b1011_????: begin
               unique case (op[3:0])
                  4'h0, 4'h2, 4'h3, 4'h4, 4'h5: next_acc = mem_val;
                  4'h1, 4'h6, 4'h7, 4'h8, 4'h9: begin
                     next_acc = mem_val;
                     data_req.write = 1'b1;
                  end
                  4'hA, 4'hB, 4'hC: begin
                     data_req.write = 1'b1;
                     data_req.wdata = byte1;
                  end
                  4'hD, 4'hE: begin
                     data_req.write = 1'b1;
                     data_req.wdata = byte2;
                  end
                  default: test_skip = (mem_val != byte2);
               endcase
               // Pointer steps after the access
               unique case (op[3:0])
                  4'h2, 4'h6, 4'hA: next_b = ptr_b + 8'h01;
                  4'h3, 4'h7, 4'hB: next_b = ptr_b - 8'h01;
                  4'h4, 4'h8:       next_x = ptr_x + 8'h01;
                  4'h5, 4'h9:       next_x = ptr_x - 8'h01;
                  default: ;
               endcase
            end
            8'b1100_????: begin
               unique case (op)
                  8'hC0: next_acc = 8'h00;
                  8'hC1: next_acc = acc + 8'h01;
                  8'hC2: next_acc = acc - 8'h01;
                  OP_TABLE: next_acc = prog_data;
                  8'hC4: {next_acc, next_psw.carry} = {psw.carry, acc};
                  8'hC5: {next_psw.carry, next_acc} = {acc, psw.carry};
                  8'hC6: next_acc = {acc[3:0], acc[7:4]};
                  8'hC7: {next_psw.carry, next_psw.half_carry_flag} = 2'h3;
                  8'hC8: {next_psw.carry, next_psw.half_carry_flag} = 2'h0;
                  8'hC9: test_skip = !psw.carry;
                  8'hCA: test_skip = psw.carry;
                  OP_POP: begin
                     next_sp = sp + 8'h01;
                     next_acc = mem_val;
                  end
                  8'hCD: clear_soft_pending = 1'b1;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   assign mapped_write = data_req.write && is_mapped(data_req.addr);

   // ----------------------------------------------------------------
   // Sequencer: fetch, operand bytes, execute, skip
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= ST_OPCODE;
         op <= RESET_BYTE;
         byte1 <= RESET_BYTE;
         byte2 <= RESET_BYTE;
         operand_index <= 1'b0;
         skip <= 1'b0;
         {pc_high_part, pc_low_part} <= RESET_PC;
      end else begin
         unique case (state)
            ST_OPCODE: begin
               op <= prog_data;
               {pc_high_part, pc_low_part} <= pc_next;
               operand_index <= 1'b0;
               if (instr_length(prog_data) != 2'h1) state <= ST_OPERAND;
               else if (skip) skip <= 1'b0;
               else state <= ST_EXECUTE;
            end
            ST_OPERAND: begin
               if (!operand_index) byte1 <= prog_data;
               else byte2 <= prog_data;
               {pc_high_part, pc_low_part} <= pc_next;
               operand_index <= 1'b1;
               if ({1'b0, operand_index} + 2'h2 == instr_length(op)) begin
                  state <= skip ? ST_OPCODE : ST_EXECUTE;
                  skip <= 1'b0;
               end
            end
            ST_EXECUTE: begin
               skip <= test_skip;
               if (op == OP_VECTOR) begin
                  pc_high_part <= prog_data[6:0];
                  state <= ST_VECTOR_LOW;
               end else begin
                  state <= ST_OPCODE;
               end
            end
            ST_VECTOR_LOW: begin
               pc_low_part <= prog_data;
               state <= ST_OPCODE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers, flags and mapped writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         acc <= RESET_BYTE;
         last_sub <= 1'b0;
      end else begin
         acc <= next_acc;
         last_sub <= next_last_sub;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ptr_b <= RESET_BYTE;
         ptr_x <= RESET_BYTE;
         sp <= RESET_SP;
      end else begin
         ptr_b <= (mapped_write && data_req.addr == ADDR_B) ? data_req.wdata : next_b;
         ptr_x <= (mapped_write && data_req.addr == ADDR_X) ? data_req.wdata : next_x;
         sp <= (mapped_write && data_req.addr == ADDR_SP) ? data_req.wdata : next_sp;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         psw <= '0;
      end else if (mapped_write && data_req.addr == ADDR_PSW) begin
         psw <= '{carry: data_req.wdata[PSW_CARRY_BIT], half_carry_flag: data_req.wdata[PSW_HALF_BIT],
                  global_irq_enable: data_req.wdata[PSW_GIE_BIT]};
      end else begin
         psw <= next_psw;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_skip_one_byte: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_OPCODE && skip && instr_length(prog_data) == 2'h1 |=> state == ST_OPCODE && !skip)
      else $error("one-byte skip took more than one cycle");
   a_skip_no_effect: assert property (@(posedge clk_sys) disable iff (!reset_n)
      skip |=> state != ST_EXECUTE && $stable(acc) && $stable(ptr_b) && $stable(ptr_x)
      && $stable(sp) && $stable(psw))
      else $error("skipped instruction changed state");
   a_adc_sum: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == {GRP_ALU_IMM, FN_ADC}
      |=> acc == 8'($past(acc) + $past(byte1) + {7'h00, $past(psw.carry)}))
      else $error("add with carry result wrong");
   a_subtract_borrow_op_borrow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == {GRP_ALU_IMM, FN_SUBTRACT_BORROW_OP}
      |=> acc == 8'($past(acc) - $past(byte1) - 8'h01 + {7'h00, $past(psw.carry)}))
      else $error("subtract with carry result wrong");
   a_push_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == OP_PUSH |-> data_req.write && data_req.addr == sp ##1 sp == $past(sp) - 8'h01)
      else $error("push order wrong");
   a_pop_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == OP_POP |-> data_req.addr == 8'(sp + 8'h01) ##1 sp == 8'($past(sp) + 8'h01))
      else $error("pop order wrong");
   a_rotate_right: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == 8'hC4 |=> psw.carry == $past(acc[0]) && acc[7] == $past(psw.carry))
      else $error("rotate right through carry wrong");
   a_table_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == OP_TABLE |-> prog_addr == {pc_high_part, acc} ##1 acc == $past(prog_data))
      else $error("table lookup address wrong");
   a_vector_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == OP_VECTOR |=> state == ST_VECTOR_LOW ##1
      state == ST_OPCODE && pc_low_part == $past(prog_data))
      else $error("vector load sequence wrong");
   a_nibble_test: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op[7:4] == GRP_PTR_NIBBLE |=> skip == ($past(ptr_b[3:0]) == $past(op[3:0])))
      else $error("pointer nibble test wrong");
   a_pointer_post: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_EXECUTE && op == 8'hB2 |-> data_req.addr == ptr_b ##1 ptr_b == 8'($past(ptr_b) + 8'h01))
      else $error("pointer post increment wrong");

endmodule // cpu_instruction_execute

// >>> sim/exec_mem_model.sv
// Program memory and data memory model facing the core
`timescale 1ns/1ns
module exec_mem_model
   import cpu_exec_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic [14:0]  prog_addr,
   output logic [7:0]        prog_data,
   input  wire data_req_type data_req,
   output logic [7:0]        data_rdata
);
   logic [7:0] rom [0:32767];
   logic [7:0] ram [0:255];
   // Both reads answer in the same cycle as the address
   assign prog_data  = rom[prog_addr];
   assign data_rdata = ram[data_req.addr];
   // Core-held registers live inside the core, so those writes are dropped
   always @(posedge clk_sys) begin
      if (data_req.write && !(data_req.addr inside {ADDR_PSW, ADDR_X, ADDR_SP, ADDR_B}))
         ram[data_req.addr] <= data_req.wdata;
   end
endmodule // exec_mem_model

// >>> sim/tb.sv
// Self-checking bench for the instruction execute core
`timescale 1ns/1ns
module tb
   import cpu_exec_pkg::*;
;
   logic         clk_sys;
   logic         reset_n = 1'b0;
   logic [14:0]  prog_addr;
   logic [7:0]   prog_data, data_rdata;
   data_req_type data_req;
   psw_type      psw_flags;
   logic         clear_soft_pending, skip_active;
   int           miscompares = 0, n_tests = 0, pulses = 0;
   logic [7:0]   prog [$];
   // Fields: acc carry length | op byte1 | byte2 acc_out | carry_out half_out
   logic [55:0]  rows [23] = '{
      56'h0F12_9101_0012_01, 56'hFF02_9101_0001_11, 56'h0512_9203_0003_11, 56'h0312_9205_00FF_00,
      56'h0F02_60F0_000F_00, 56'h0F02_6001_0010_00, 56'h5502_9655_0056_00, 56'h5502_9654_0055_00,
      56'h5502_9755_0055_00, 56'h5502_9854_0056_00, 56'h5502_9855_0055_00, 56'h1011_C900_0011_11,
      56'h1001_C900_0010_00, 56'h1001_CA00_0011_00, 56'h8101_C400_0041_10, 56'h8011_C500_0002_11,
      56'h0401_EA00_0005_00, 56'h0401_E900_0004_00, 56'h0001_4000_0000_00, 56'h0001_4100_0001_00,
      56'h0903_9101_6611_00, 56'h2313_9205_6619_10, 56'h9903_9101_6601_10};

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   cpu_instruction_execute DUT (.clk_sys(clk_sys), .reset_n(reset_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .data_req(data_req), .data_rdata(data_rdata), .vector_addr(15'h0004),
      .clear_soft_pending(clear_soft_pending), .psw_flags(psw_flags), .skip_active(skip_active));

   exec_mem_model mem (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data),
      .data_req(data_req), .data_rdata(data_rdata));

   always @(negedge clk_sys) begin
      if (clear_soft_pending === 1'b1)
         pulses++;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Loads a program, resets the core over it and lets it run
   task automatic run(input int cycles);
      @(negedge clk_sys);
      reset_n = 1'b0;
      for (int i = 0; i < 32768; i++)
         mem.rom[i] = (i < prog.size()) ? prog[i] : 8'hCE;
      for (int i = 0; i < 256; i++)
         mem.ram[i] = 8'h00;
      repeat (4) @(negedge clk_sys);
      check({5'h00, psw_flags}, 8'h00);
      check({prog_addr[14:8], skip_active}, 8'h00);
      check(prog_addr[7:0], 8'h00);
      pulses = 0;
      reset_n = 1'b1;
      repeat (cycles) @(negedge clk_sys);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #100_000;
      miscompares++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Table rows, then pointer, memory, stack and vector programs
   // ----------------------------------------------------------------
   initial begin
      foreach (rows[r]) begin
         prog = '{8'h99, rows[r][55:48], (rows[r][47:44] != 4'h0) ? 8'hC7 : 8'hC8};
         for (int k = 0; k < int'(rows[r][43:40]); k++)
            prog.push_back(rows[r][39-8*k -: 8]);
         prog.push_back(8'hC1);
         prog.push_back(8'h67);
         run(20);
         check(mem.ram[8'h2F], rows[r][15:8]);
         check({7'h00, psw_flags.carry}, {4'h0, rows[r][7:4]});
         check({7'h00, psw_flags.half_carry_flag}, {4'h0, rows[r][3:0]});
         $display("row %0d done", r);
      end
      prog = '{8'hBE, 8'hFE, 8'h10, 8'hBA, 8'h77, 8'hBC, 8'h88, 8'hD3, 8'h10, 8'hBD, 8'h12, 8'h01,
               8'hF0, 8'h12, 8'hC1, 8'h67, 8'hC0, 8'hC3, 8'h67};
      run(45);
      check(mem.ram[8'h10], 8'h7F);
      check(mem.ram[8'h11], 8'h88);
      check(mem.ram[8'h12], 8'h00);
      check(mem.ram[8'h2F], 8'h00);
      check(mem.ram[8'h2E], 8'hBE);
      $display("pointer and memory program done");
      prog = '{8'h99, 8'h11, 8'h67, 8'h99, 8'h22, 8'hCB, 8'hBD, 8'h40, 8'h33, 8'hAA, 8'h40, 8'hCD,
               8'hBF, 8'h40, 8'h11, 8'hC1, 8'hBF, 8'h40, 8'h12, 8'hC1, 8'h67};
      run(45);
      check(mem.ram[8'h2F], 8'h34);
      check(mem.ram[8'h40], 8'h11);
      check(pulses[7:0], 8'h01);
      $display("stack and exchange program done");
      prog = '{8'hCC, 8'h99, 8'hA5, 8'h67, 8'h01, 8'h00};
      while (prog.size() < 256)
         prog.push_back(8'hCE);
      prog = {prog, 8'h99, 8'h5A, 8'h67, 8'hBE, 8'hFE, 8'h2F, 8'hB2, 8'hC1, 8'h67, 8'hBE, 8'hEF, 8'h81};
      run(30);
      check(mem.ram[8'h2F], 8'h5A);
      check(mem.ram[8'h2E], 8'h5B);
      check({5'h00, psw_flags}, 8'h05);
      $display("vector and status program done");
      report_and_stop();
   end
endmodule // tb
